// File: hw/questionable_status_group.sv
`timescale 1ns/1ps
`default_nettype none
module questionable_status_group
   import questionable_status_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // status command strobes
   input wire logic clearStatus,
   input wire logic statusPreset,
   input wire logic resetCmd,
   // register writes
   input wire logic [REG_W-1:0] wrData,
   input wire logic wrPtr,
   input wire logic wrNtr,
   input wire logic wrEnable,
   input wire logic wrAutoCal,
   // queries
   input wire logic qryStrobe,
   input wire logic [2:0] qrySel,
   // measurement events
   input wire logic calFail,
   input wire logic limitFail,
   input wire logic paramDiscard,
   // read back and state
   output logic [REG_W-1:0] qryData_reg,
   output logic qryValid_reg,
   output logic [REG_W-1:0] cond_reg,
   output logic [REG_W-1:0] event_reg,
   output logic autoCal_reg,
   output logic summary_reg
);

   //************************************************************
   // function
   //************************************************************
   function automatic logic [REG_W-1:0] place_cond(input logic [NUM_COND-1:0] v);
      logic [REG_W-1:0] r;
      r = '0;
      r[BIT_TIME] = v[0];
      r[BIT_FREQ] = v[1];
      r[BIT_PHASE] = v[2];
      return r;
   endfunction

   function automatic logic [NUM_COND-1:0] pick_cond(input logic [REG_W-1:0] r);
      return {r[BIT_PHASE], r[BIT_FREQ], r[BIT_TIME]};
   endfunction

   //************************************************************
   // state
   //************************************************************
   logic [REG_W-1:0] ptr_reg, ptr_next;
   logic [REG_W-1:0] ntr_reg, ntr_next;
   logic [REG_W-1:0] enable_reg, enable_next;
   logic [REG_W-1:0] cond_next, event_next;
   logic [REG_W-1:0] qryData_next;
   logic qryValid_next, summary_next, autoCal_next;
   logic [NUM_COND-1:0] condHit;
   logic [REG_W-1:0] srcSet;
   logic evClear;

   cond_edge_filter #(
      .W(NUM_COND)
   ) u_filter (
      .clk(clk),
      .rst_b(rst_b),
      .cond(pick_cond(cond_reg)),
      .posEn(pick_cond(ptr_reg)),
      .negEn(pick_cond(ntr_reg)),
      .hit(condHit)
   );

   //************************************************************
   // configuration
   //************************************************************
   always_comb begin
      ptr_next = ptr_reg;
      ntr_next = ntr_reg;
      enable_next = enable_reg;
      autoCal_next = autoCal_reg;
      if (statusPreset) begin
         ptr_next = PTR_DEFAULT;
         ntr_next = NTR_DEFAULT;
         enable_next = ENABLE_DEFAULT;
      end else begin
         if (wrPtr) begin
            ptr_next = wrData & USED_MASK;
         end
         if (wrNtr) begin
            ntr_next = wrData & USED_MASK;
         end
         if (wrEnable) begin
            enable_next = wrData & USED_MASK;
         end
      end
      // autocal enable lives only here, never in a save image
      if (resetCmd) begin
         autoCal_next = AUTOCAL_DEFAULT;
      end else if (wrAutoCal) begin
         autoCal_next = wrData[0];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ptr_reg <= PTR_DEFAULT;
         ntr_reg <= NTR_DEFAULT;
         enable_reg <= ENABLE_DEFAULT;
         autoCal_reg <= AUTOCAL_DEFAULT;
      end else begin
         ptr_reg <= ptr_next;
         ntr_reg <= ntr_next;
         enable_reg <= enable_next;
         autoCal_reg <= autoCal_next;
      end
   end

   //************************************************************
   // condition, event, summary
   //************************************************************
   always_comb begin
      cond_next = autoCal_reg ? '0 : COND_MASK;
      srcSet = '0;
      srcSet[BIT_CAL_ERR] = calFail;
      srcSet[BIT_LIMIT] = limitFail;
      srcSet[BIT_CMD_WARN] = paramDiscard;
      evClear = clearStatus | (qryStrobe && qrySel == 3'(SEL_EVENT));
      // a new event in the clearing cycle survives the clear
      event_next = ((evClear ? '0 : event_reg) | srcSet | place_cond(condHit))
                   & USED_MASK;
      summary_next = |(event_next & enable_next);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cond_reg <= '0;
         event_reg <= '0;
         summary_reg <= 1'b0;
      end else begin
         cond_reg <= cond_next;
         event_reg <= event_next;
         summary_reg <= summary_next;
      end
   end

   //************************************************************
   // query read back
   //************************************************************
   always_comb begin
      qryValid_next = qryStrobe;
      qryData_next = qryData_reg;
      if (qryStrobe) begin
         case (qrySel)
            3'(SEL_EVENT): qryData_next = event_reg;
            3'(SEL_COND): qryData_next = cond_reg;
            3'(SEL_ENABLE): qryData_next = enable_reg;
            3'(SEL_PTR): qryData_next = ptr_reg;
            3'(SEL_NTR): qryData_next = ntr_reg;
            3'(SEL_AUTOCAL): qryData_next = {15'h0000, autoCal_reg};
            default: qryData_next = '0;
         endcase
         qryData_next[BIT_SIGN] = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         qryData_reg <= '0;
         qryValid_reg <= 1'b0;
      end else begin
         qryData_reg <= qryData_next;
         qryValid_reg <= qryValid_next;
      end
   end

   //************************************************************
   // assertions
   //************************************************************
   a_cond_follows_autocal: assert property (@(posedge clk) disable iff (!rst_b)
      ##1 (cond_reg[BIT_TIME] == !$past(autoCal_reg)))
      else $error("time condition does not track autocal");

   a_freq_phase_cond: assert property (@(posedge clk) disable iff (!rst_b)
      cond_reg[BIT_FREQ] == cond_reg[BIT_TIME] && cond_reg[BIT_PHASE] == cond_reg[BIT_TIME])
      else $error("frequency or phase condition differs from time");

   a_cal_fail_sets: assert property (@(posedge clk) disable iff (!rst_b)
      calFail |=> event_reg[BIT_CAL_ERR])
      else $error("calibration failure not latched");

   a_limit_each_time: assert property (@(posedge clk) disable iff (!rst_b)
      limitFail && (clearStatus || (qryStrobe && qrySel == 3'(SEL_EVENT)))
      |=> event_reg[BIT_LIMIT])
      else $error("repeated out-of-limit lost");

   a_warn_sets: assert property (@(posedge clk) disable iff (!rst_b)
      paramDiscard |=> event_reg[BIT_CMD_WARN])
      else $error("command warning not latched");

   a_sign_zero: assert property (@(posedge clk) disable iff (!rst_b)
      !qryData_reg[BIT_SIGN] && !event_reg[BIT_SIGN])
      else $error("bit 15 not zero");

   a_reset_autocal: assert property (@(posedge clk) disable iff (!rst_b)
      resetCmd |=> autoCal_reg ##1 (cond_reg == '0))
      else $error("reset command did not restore autocal");

   a_rise_event: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(cond_reg[BIT_TIME]) && ptr_reg[BIT_TIME] |=> event_reg[BIT_TIME])
      else $error("rising condition with positive filter not latched");

   a_sticky_event: assert property (@(posedge clk) disable iff (!rst_b)
      event_reg[BIT_LIMIT] && !clearStatus && !(qryStrobe && qrySel == 3'(SEL_EVENT))
      |=> event_reg[BIT_LIMIT])
      else $error("event bit dropped without clear");

   a_preset_clears: assert property (@(posedge clk) disable iff (!rst_b)
      statusPreset |=> enable_reg == ENABLE_DEFAULT && !summary_reg)
      else $error("preset did not clear enable");

   a_filters_kept: assert property (@(posedge clk) disable iff (!rst_b)
      clearStatus && !statusPreset && !wrPtr && !wrNtr |=> $stable(ptr_reg) && $stable(ntr_reg))
      else $error("clear-status changed filters");

   a_summary_value: assert property (@(posedge clk) disable iff (!rst_b)
      summary_reg == |(event_reg & enable_reg))
      else $error("summary mismatch");

endmodule // questionable_status_group
`default_nettype wire

// File: hw/questionable_status_pkg.sv
//****************************************************************
//****************************************************************
package questionable_status_pkg;

   localparam int REG_W = 16;

   // bit positions
   localparam int BIT_TIME = 2;
   localparam int BIT_FREQ = 5;
   localparam int BIT_PHASE = 6;
   localparam int BIT_CAL_ERR = 8;
   localparam int BIT_LIMIT = 10;
   localparam int BIT_CMD_WARN = 14;
   localparam int BIT_SIGN = 15;
   localparam int NUM_COND = 3;

   localparam logic [REG_W-1:0] COND_MASK = 16'h0064;
   localparam logic [REG_W-1:0] EVENT_SRC_MASK = 16'h4500;
   localparam logic [REG_W-1:0] USED_MASK = 16'h4564;

   // defaults after power-on or status preset; autocal default after power-on or reset command
   localparam logic [REG_W-1:0] PTR_DEFAULT = 16'h7fff & USED_MASK;
   localparam logic [REG_W-1:0] NTR_DEFAULT = 16'h0000;
   localparam logic [REG_W-1:0] ENABLE_DEFAULT = 16'h0000;
   localparam logic AUTOCAL_DEFAULT = 1'b1;

   // query selector codes
   typedef enum logic [2:0] {
      SEL_EVENT,
      SEL_COND,
      SEL_ENABLE,
      SEL_PTR,
      SEL_NTR,
      SEL_AUTOCAL
   } query_sel_e;

endpackage

// File: hw/cond_edge_filter.sv
`timescale 1ns/1ps
`default_nettype none
module cond_edge_filter
   import questionable_status_pkg::*;
#(
   parameter int W = NUM_COND
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // condition and filters
   input wire logic [W-1:0] cond,
   input wire logic [W-1:0] posEn,
   input wire logic [W-1:0] negEn,
   // qualified transitions
   output logic [W-1:0] hit
);

   logic [W-1:0] prev_reg;
   logic [W-1:0] prev_next;

   initial begin
      if (W < 1) begin
         $error("cond_edge_filter needs at least one bit");
      end
   end

   always_comb begin
      prev_next = cond;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prev_reg <= '0;
      end else begin
         prev_reg <= prev_next;
      end
   end

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         // rising needs positive filter, falling needs negative filter
         assign hit[i] = (posEn[i] & cond[i] & ~prev_reg[i]) |
                         (negEn[i] & ~cond[i] & prev_reg[i]);
      end
   endgenerate

endmodule // cond_edge_filter
`default_nettype wire

// File: verif/scpi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module scpi_host_model
   import questionable_status_pkg::*;
(
   // clock
   input wire logic clk,
   // command strobes, write data and query select
   output logic [10:0] stb,
   output logic [REG_W-1:0] wrData,
   output logic [2:0] qrySel
);
   //****************************************
   // one command cycle, driven after the edge
   //****************************************
   initial begin
      stb = '0;
      wrData = '0;
      qrySel = '0;
   end

   task automatic issue(input logic [10:0] m, input logic [REG_W-1:0] d, input logic [2:0] s);
      @(posedge clk);
      #2;
      stb = m;
      wrData = d;
      qrySel = s;
      @(posedge clk);
      #2;
      stb = '0;
      // released bus shows no stale value
      wrData = ~d;
      qrySel = ~s;
   endtask
endmodule // scpi_host_model
`default_nettype wire

// File: verif/questionable_status_group_test.sv
`timescale 1ns/1ps
`default_nettype none
module questionable_status_group_test;
   import questionable_status_pkg::*;
   logic clk;
   logic rst_b;
   logic [10:0] stb;
   logic [REG_W-1:0] wrData, qryData_reg, cond_reg, event_reg;
   logic [2:0] qrySel;
   logic qryValid_reg, autoCal_reg, summary_reg;
   int err_count = 0;
   int comparisons = 0;
   int cycles = 0;
   int ptr, ntr, en, ev, ac, cnd, qd, i;
   logic [31:0] rng = 32'h64812faf;
   logic [31:0] r;

   scpi_host_model i_host (.clk(clk), .stb(stb), .wrData(wrData), .qrySel(qrySel));

   questionable_status_group i_dut (
      .clk(clk), .rst_b(rst_b), .clearStatus(stb[0]), .statusPreset(stb[1]),
      .resetCmd(stb[2]), .wrData(wrData), .wrPtr(stb[3]), .wrNtr(stb[4]),
      .wrEnable(stb[5]), .wrAutoCal(stb[6]), .qryStrobe(stb[7]), .qrySel(qrySel),
      .calFail(stb[8]), .limitFail(stb[9]), .paramDiscard(stb[10]),
      .qryData_reg(qryData_reg), .qryValid_reg(qryValid_reg), .cond_reg(cond_reg),
      .event_reg(event_reg), .autoCal_reg(autoCal_reg), .summary_reg(summary_reg)
   );

   //****************************************
   // helpers
   //****************************************
   function automatic logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic mreset();
      // positive filter defaults to every used bit, as the design loads it
      ptr = 'h4564;
      ntr = 0;
      en = 0;
      ev = 0;
      ac = 1;
      cnd = 0;
   endtask

   // one command through the host, then the model, then the compare
   task automatic step(input logic [10:0] m, input logic [15:0] d, input logic [2:0] s);
      int nc;
      i_host.issue(m, d, s);
      qd = s == 0 ? ev : s == 1 ? cnd : s == 2 ? en : s == 3 ? ptr : s == 4 ? ntr : s == 5 ? ac : 0;
      check("qryValid", 16'(qryValid_reg), 16'(m[7]));
      if (m[7]) begin
         check("qryData", qryData_reg, 16'(qd));
      end
      if (m[0] || (m[7] && s == 0)) begin
         ev = 0;
      end
      ev |= (m[8] ? 'h100 : 0) | (m[9] ? 'h400 : 0) | (m[10] ? 'h4000 : 0);
      if (m[1]) begin
         ptr = 'h4564;
         ntr = 0;
         en = 0;
      end else begin
         ptr = m[3] ? d & 'h4564 : ptr;
         ntr = m[4] ? d & 'h4564 : ntr;
         en = m[5] ? d & 'h4564 : en;
      end
      ac = m[2] ? 1 : m[6] ? d[0] : ac;
      nc = ac ? 0 : 'h64;
      ev |= nc > cnd ? ptr & 'h64 : nc < cnd ? ntr & 'h64 : 0;
      cnd = nc;
      repeat (2) @(posedge clk);
      #2;
      check("event", event_reg, 16'(ev));
      check("cond", cond_reg, 16'(cnd));
      check("autoCal", 16'(autoCal_reg), 16'(ac));
      check("summary", 16'(summary_reg), 16'((ev & en) != 0));
   endtask

   //****************************************
   // clock, timeout and sequence
   //****************************************
   initial begin
      clk = 0;
      forever #12.5 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         final_report();
      end
   end

   initial begin
      rst_b = 0;
      mreset();
      repeat (5) @(posedge clk);
      #2;
      rst_b = 1;
      step(11'h080, 16'h0000, 3'h3);
      // all four filter combinations, rising and falling condition
      for (i = 0; i < 4; i++) begin
         step(11'h002, 16'hffff, 3'h0);
         step(11'h008, i[0] ? 16'hffff : 16'h0000, 3'h0);
         step(11'h010, i[1] ? 16'hffff : 16'h0000, 3'h4);
         step(11'h0a0, 16'hffff, 3'h2);
         step(11'h040, 16'h0000, 3'h1);
         step(11'h040, 16'h0001, 3'h0);
         step(11'h080, 16'h0000, 3'h0);
      end
      step(11'h700, 16'h0000, 3'h0);
      step(11'h601, 16'h0000, 3'h0);
      step(11'h044, 16'h0000, 3'h0);
      step(11'h022, 16'hffff, 3'h0);
      step(11'h380, 16'h0000, 3'h0);
      for (i = 0; i < 80; i++) begin
         r = xs();
         step(11'(r & xs()), r[31:16], r[15:13]);
      end
      @(posedge clk);
      #2;
      rst_b = 0;
      mreset();
      @(posedge clk);
      #2;
      rst_b = 1;
      step(11'h080, 16'h0000, 3'h4);
      final_report();
   end
endmodule // questionable_status_group_test
`default_nettype wire
